/* File: rtl/wor_option_regs.sv */
`timescale 1ns/1ps
// Operation
// - one write per register after each reset
// - reset clears fields; trip bits need power-on
// - registers at two addresses, always readable
// - top bit disconnects interrupt pin pull-up
// - bits four and three select trip level
// - period bit picks short or long watchdog
// - disable bit turns low-voltage inhibit off
// - short-recovery bit picks 32 or 4096 cycles
// - stop exit by reset uses long delay
// - stop enable, else stop is illegal opcode
// - watchdog disable bit, zero keeps it running
module wor_option_regs
  import wor_pkg::*;
#(
  parameter logic [17:0] WDOG_SHORT = WDOG_SHORT_CYC,
  parameter logic [17:0] WDOG_LONG = WDOG_LONG_CYC,
  parameter logic [12:0] REC_SHORT = REC_SHORT_CYC,
  parameter logic [12:0] REC_LONG = REC_LONG_CYC
) (
  // clock and resets
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic por_n,
  // register port
  input wire wor_pkg::wor_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  // option outputs
  output wor_pkg::wor_opts_s opts,
  // stop control
  input wire logic stop_instr,
  input wire logic wake_pin,
  output logic in_stop,
  output logic cpu_resume,
  output logic illegal_opcode
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (REC_LONG == 13'h0000 || REC_SHORT == 13'h0000) begin : g_bad_rec
    $error("recovery counts must be nonzero");
  end
  if (WDOG_SHORT == 18'h00000 || WDOG_LONG == 18'h00000) begin : g_bad_wdog
    $error("watchdog periods must be nonzero");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // ordinary reset and power-on both clear the system fields, so the
  // two asynchronous sources are merged before their synchroniser
  logic rst_any_n;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic por_meta_ff;
  logic por_sync_ff;
  logic sys_rst_n;
  logic por_rst_n;

  assign rst_any_n = reset_n & por_n;

  always_ff @(posedge mclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      por_meta_ff <= 1'b0;
      por_sync_ff <= 1'b0;
    end else begin
      por_meta_ff <= 1'b1;
      por_sync_ff <= por_meta_ff;
    end
  end

  assign sys_rst_n = rst_sync_ff;
  assign por_rst_n = por_sync_ff;

  // ----------------------------------------------------------------
  // write decode and write-once guards
  // ----------------------------------------------------------------
  logic [NUM_REGS-1:0] hit;
  logic [NUM_REGS-1:0] written_ff;
  logic [NUM_REGS-1:0] wr_accept;

  assign hit[IDX_PIN_TRIP] = (bus_req.addr == ADDR_PIN_TRIP);
  assign hit[IDX_SYS_OPTS] = (bus_req.addr == ADDR_SYS_OPTS);

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_once
    assign wr_accept[i] = bus_req.wr && hit[i] && !written_ff[i];

    always_ff @(posedge mclk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
        written_ff[i] <= 1'b0;
      end else if (wr_accept[i]) begin
        written_ff[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // option storage
  // ----------------------------------------------------------------
  logic pullup_disc_ff;
  logic [1:0] trip_ff;
  logic [7:0] sys_ff;
  logic [7:0] nxt_sys;
  logic [1:0] nxt_trip;

  assign nxt_sys = bus_req.wdata & SYS_WMASK;
  assign nxt_trip = {bus_req.wdata[PT_TRIP_HI_BIT], bus_req.wdata[PT_TRIP_LO_BIT]};

  // pull-up and system fields fall back to zero on any reset
  always_ff @(posedge mclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pullup_disc_ff <= 1'b0;
      sys_ff <= RESET_BYTE;
    end else begin
      if (wr_accept[IDX_PIN_TRIP]) begin
        pullup_disc_ff <= bus_req.wdata[PT_PULLUP_DISC_BIT];
      end
      if (wr_accept[IDX_SYS_OPTS]) begin
        sys_ff <= nxt_sys;
      end
    end
  end

  // trip level survives ordinary resets; only power-on clears it
  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      trip_ff <= 2'b00;
    end else if (wr_accept[IDX_PIN_TRIP] && sys_rst_n) begin
      trip_ff <= nxt_trip;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] pt_view;
  logic [7:0] rd_mux;
  logic [7:0] rdata_ff;

  always_comb begin
    pt_view = RESET_BYTE;
    pt_view[PT_PULLUP_DISC_BIT] = pullup_disc_ff;
    pt_view[PT_TRIP_HI_BIT] = trip_ff[1];
    pt_view[PT_TRIP_LO_BIT] = trip_ff[0];
  end

  assign rd_mux = hit[IDX_PIN_TRIP] ? pt_view :
                  hit[IDX_SYS_OPTS] ? sys_ff : READ_UNMAPPED;

  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      rdata_ff <= READ_UNMAPPED;
    end else begin
      rdata_ff <= bus_req.rd ? rd_mux : READ_UNMAPPED;
    end
  end

  assign bus_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // option outputs
  // ----------------------------------------------------------------
  wor_opts_s nxt_opts;
  wor_opts_s opts_ff;

  always_comb begin
    nxt_opts.irq_pullup_en = !pullup_disc_ff;
    nxt_opts.trip_level = trip_ff;
    nxt_opts.lv_monitor_en = !sys_ff[SYS_LV_DISABLE_BIT];
    nxt_opts.watchdog_en = !sys_ff[SYS_WDOG_DIS_BIT];
    nxt_opts.watchdog_period = sys_ff[SYS_WDOG_PERIOD_BIT] ? WDOG_SHORT : WDOG_LONG;
    nxt_opts.stop_enable = sys_ff[SYS_STOP_EN_BIT];
  end

  // power-on only, so the trip level on the output rides through resets
  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      opts_ff <= '{irq_pullup_en: 1'b1, trip_level: 2'b00, lv_monitor_en: 1'b1,
                   watchdog_en: 1'b1, watchdog_period: WDOG_LONG, stop_enable: 1'b0};
    end else begin
      opts_ff <= nxt_opts;
    end
  end

  assign opts = opts_ff;

  // ----------------------------------------------------------------
  // wake pin synchroniser
  // ----------------------------------------------------------------
  logic wake_meta_ff;
  logic wake_sync_ff;

  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      wake_meta_ff <= 1'b0;
      wake_sync_ff <= 1'b0;
    end else begin
      wake_meta_ff <= wake_pin;
      wake_sync_ff <= wake_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // stop entry and recovery
  // ----------------------------------------------------------------
  // the state sits on power-on reset so that a stop ended by an
  // ordinary reset is still known after that reset is released
  wor_stop_e state_ff;
  wor_stop_e nxt_state;
  logic tmr_start;
  logic [12:0] tmr_load;
  logic tmr_done;
  logic stop_ok;
  logic stop_bad;
  logic in_stop_ff;
  logic resume_ff;
  logic illegal_ff;

  assign stop_ok = stop_instr && sys_rst_n && sys_ff[SYS_STOP_EN_BIT];
  assign stop_bad = stop_instr && sys_rst_n && !sys_ff[SYS_STOP_EN_BIT];

  always_comb begin
    nxt_state = state_ff;
    tmr_start = 1'b0;
    tmr_load = REC_LONG;
    unique case (state_ff)
      WOR_RUN: begin
        if (stop_ok && state_ff == WOR_RUN) begin
          nxt_state = WOR_STOPPED;
        end
      end
      WOR_STOPPED: begin
        if (!sys_rst_n) begin
          nxt_state = WOR_RST_HOLD;
        end else if (wake_sync_ff) begin
          nxt_state = WOR_RECOVER;
          tmr_start = 1'b1;
          tmr_load = sys_ff[SYS_SHORT_REC_BIT] ? REC_SHORT : REC_LONG;
        end
      end
      WOR_RST_HOLD: begin
        if (sys_rst_n) begin
          nxt_state = WOR_RECOVER;
          tmr_start = 1'b1;
          tmr_load = REC_LONG;
        end
      end
      WOR_RECOVER: begin
        if (tmr_done) begin
          nxt_state = WOR_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      state_ff <= WOR_RUN;
      in_stop_ff <= 1'b0;
      resume_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      in_stop_ff <= (nxt_state != WOR_RUN);
      resume_ff <= (state_ff == WOR_RECOVER) && tmr_done;
      illegal_ff <= stop_bad && (state_ff == WOR_RUN);
    end
  end

  wor_recovery_timer #(
    .CNT_W(REC_CNT_W)
  ) u_rec_timer (
    .mclk(mclk),
    .rst_n(por_rst_n),
    .start(tmr_start),
    .load(tmr_load),
    .busy(),
    .done(tmr_done)
  );

  assign in_stop = in_stop_ff;
  assign cpu_resume = resume_ff;
  assign illegal_opcode = illegal_ff;

endmodule

/* File: include/wor_pkg.sv */
package wor_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [15:0] ADDR_PIN_TRIP = 16'h001e;
  localparam logic [15:0] ADDR_SYS_OPTS = 16'h001f;
  localparam int unsigned NUM_REGS = 2;
  localparam int unsigned IDX_PIN_TRIP = 0;
  localparam int unsigned IDX_SYS_OPTS = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned PT_PULLUP_DISC_BIT = 7;
  localparam int unsigned PT_TRIP_HI_BIT = 4;
  localparam int unsigned PT_TRIP_LO_BIT = 3;
  localparam int unsigned SYS_WDOG_PERIOD_BIT = 7;
  localparam int unsigned SYS_LV_DISABLE_BIT = 4;
  localparam int unsigned SYS_SHORT_REC_BIT = 3;
  localparam int unsigned SYS_STOP_EN_BIT = 1;
  localparam int unsigned SYS_WDOG_DIS_BIT = 0;
  localparam logic [7:0] SYS_WMASK = 8'h9b;

  // ----------------------------------------------------------------
  // timing counts, in oscillator-derived clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned REC_CNT_W = 13;
  localparam logic [12:0] REC_SHORT_CYC = 13'h0020;
  localparam logic [12:0] REC_LONG_CYC = 13'h1000;
  localparam int unsigned WDOG_W = 18;
  localparam logic [17:0] WDOG_SHORT_CYC = 18'h01ff0;
  localparam logic [17:0] WDOG_LONG_CYC = 18'h3fff0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wor_bus_req_s;

  typedef struct packed {
    logic irq_pullup_en;
    logic [1:0] trip_level;
    logic lv_monitor_en;
    logic watchdog_en;
    logic [17:0] watchdog_period;
    logic stop_enable;
  } wor_opts_s;

  typedef enum logic [1:0] {
    WOR_RUN = 2'b00,
    WOR_STOPPED = 2'b01,
    WOR_RST_HOLD = 2'b10,
    WOR_RECOVER = 2'b11
  } wor_stop_e;

endpackage

/* File: rtl/wor_recovery_timer.sv */
`timescale 1ns/1ps
module wor_recovery_timer #(
  parameter int unsigned CNT_W = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic [CNT_W-1:0] load,
  // status
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic last_tick;

  assign last_tick = busy_ff && (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});

  // a start while busy restarts the count; the caller never does this
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= last_tick && !start;
      if (start) begin
        cnt_ff <= load;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
        busy_ff <= !last_tick;
      end
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

endmodule

/* File: tb/wor_opt_assertions.sv */
`timescale 1ns/1ps
module wor_opt_chk
  import wor_pkg::*;
#(
  parameter logic [17:0] WDOG_SHORT = WDOG_SHORT_CYC,
  parameter logic [17:0] WDOG_LONG = WDOG_LONG_CYC,
  parameter logic [12:0] REC_LONG = REC_LONG_CYC
) (
  // clock, resets, bus
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire wor_pkg::wor_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata,
  // options and stop
  input wire wor_pkg::wor_opts_s opts,
  input wire logic stop_instr,
  input wire logic wake_pin,
  input wire logic in_stop,
  input wire logic cpu_resume,
  input wire logic illegal_opcode
);
  // margin covers wake sync, load and the resume pulse
  localparam int unsigned RMAX = REC_LONG + 12;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n || !por_n);
  sequence rd_pt_s;
    bus_req.rd && bus_req.addr == ADDR_PIN_TRIP;
  endsequence
  sequence rd_sys_s;
    bus_req.rd && bus_req.addr == ADDR_SYS_OPTS;
  endsequence
  sequence wake_s;
    in_stop && $rose(wake_pin);
  endsequence
  // cycles spent in stop since the wake pin rose; a counter, since the
  // long recovery is far beyond what a delay range may span
  int unsigned wake_cnt;
  always_ff @(posedge mclk) begin
    if (!reset_n || !por_n || !in_stop) begin
      wake_cnt <= 0;
    end else if (wake_cnt != 0 || $rose(wake_pin)) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
  rd_idle_zero_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not idle");
  pullup_map_a: assert property (rd_pt_s |=> bus_rdata[7] == !opts.irq_pullup_en)
    else $error("pull-up output wrong");
  trip_map_a: assert property (rd_pt_s |=> bus_rdata[4:3] == opts.trip_level)
    else $error("trip level output wrong");
  period_map_a: assert property (rd_sys_s |=>
    opts.watchdog_period == (bus_rdata[7] ? WDOG_SHORT : WDOG_LONG))
    else $error("watchdog period wrong");
  lv_map_a: assert property (rd_sys_s |=> opts.lv_monitor_en != bus_rdata[4])
    else $error("low-voltage enable wrong");
  stop_map_a: assert property (rd_sys_s |=> opts.stop_enable == bus_rdata[1])
    else $error("stop enable wrong");
  wdog_map_a: assert property (rd_sys_s |=> opts.watchdog_en != bus_rdata[0])
    else $error("watchdog enable wrong");
  illegal_op_a: assert property (stop_instr && !in_stop && !opts.stop_enable |=>
    illegal_opcode && !in_stop)
    else $error("disabled stop not refused");
  stop_entry_a: assert property (stop_instr && !in_stop && opts.stop_enable |=>
    in_stop && !illegal_opcode)
    else $error("stop not entered");
  wake_hold_a: assert property (wake_s |=> in_stop)
    else $error("stop left without recovery delay");
  resume_bound_a: assert property (wake_cnt <= RMAX)
    else $error("no resume after wake");
  resume_end_a: assert property (cpu_resume |=> !cpu_resume && !in_stop)
    else $error("resume pulse or stop level wrong");
endmodule
bind wor_option_regs wor_opt_chk #(.WDOG_SHORT(WDOG_SHORT), .WDOG_LONG(WDOG_LONG),
  .REC_LONG(REC_LONG)) u_chk (.mclk(mclk), .reset_n(reset_n), .por_n(por_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .opts(opts), .stop_instr(stop_instr),
  .wake_pin(wake_pin), .in_stop(in_stop), .cpu_resume(cpu_resume),
  .illegal_opcode(illegal_opcode));

/* File: tb/wor_option_regs_bench.sv */
`timescale 1ns/1ps
module wor_option_regs_bench;
  import wor_pkg::*;
  // short recovery counts keep the run brief
  localparam logic [12:0] RS = 13'h0004;
  localparam logic [12:0] RL = 13'h0010;
  // wake sync, timer load and the resume flop add five cycles to a wake exit
  localparam int WAKE_LAT = 5;
  // an exit by reset loads the timer on the last edge that rst waits for
  localparam int RST_LAT = 2;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic por_n = 1'b0;
  wor_bus_req_s req = '0;
  logic [7:0] rdata;
  wor_opts_s opts;
  logic stop_instr = 1'b0;
  logic wake_pin = 1'b0;
  logic in_stop;
  logic cpu_resume;
  logic illegal_opcode;
  logic rd_q = 1'b0;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  logic [31:0] seed = 32'h7eb7;
  logic [7:0] q[$];
  logic [7:0] a;
  logic [7:0] b;
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  wor_option_regs #(.REC_SHORT(RS), .REC_LONG(RL)) dut (.mclk(mclk), .reset_n(reset_n),
    .por_n(por_n), .bus_req(req), .bus_rdata(rdata), .opts(opts), .stop_instr(stop_instr),
    .wake_pin(wake_pin), .in_stop(in_stop), .cpu_resume(cpu_resume),
    .illegal_opcode(illegal_opcode));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (q.size() != 0) begin
      n_mismatch++;
    end
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(logic [15:0] ad, logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] ad, logic [7:0] e);
    @(posedge mclk);
    req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    q.push_back(e);
    @(posedge mclk);
    req.rd <= 1'b0;
  endtask
  always @(posedge mclk) rd_q <= req.rd;
  always @(negedge mclk) if (rd_q === 1'b1 && q.size() > 0) chk("rdata", q.pop_front(), rdata);
  task automatic chk_opts(logic [7:0] pt, logic [7:0] sy);
    wor_opts_s e;
    repeat (2) @(negedge mclk);
    e.irq_pullup_en = ~pt[7];
    e.trip_level = pt[4:3];
    e.lv_monitor_en = ~sy[4];
    e.watchdog_en = ~sy[0];
    e.watchdog_period = sy[7] ? WDOG_SHORT_CYC : WDOG_LONG_CYC;
    e.stop_enable = sy[1];
    chk("opts", 32'(e), 32'(opts));
  endtask
  task automatic rst(logic po);
    @(posedge mclk);
    por_n <= ~po;
    reset_n <= po;
    repeat (4) @(posedge mclk);
    por_n <= 1'b1;
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task automatic pulse_stop();
    @(posedge mclk);
    stop_instr <= 1'b1;
    @(posedge mclk);
    stop_instr <= 1'b0;
  endtask
  task automatic wait_res(output int c);
    c = 0;
    while (cpu_resume !== 1'b1) begin
      @(negedge mclk);
      c++;
      if (c > 300) begin
        n_mismatch++;
        wrap_up();
      end
    end
  endtask
  task automatic stop_run(output int c);
    pulse_stop();
    wake_pin <= 1'b1;
    wait_res(c);
    @(posedge mclk);
    wake_pin <= 1'b0;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_opts(8'h00, 8'h00);
    rd(ADDR_PIN_TRIP, 8'h00);
    rd(ADDR_SYS_OPTS, 8'h00);
    rd(16'h0020, READ_UNMAPPED);
    pulse_stop();
    @(negedge mclk);
    chk("illegal", 32'h1, 32'(illegal_opcode));
    $display("test reset done");
    seed = lfsr(seed);
    a = seed[7:0];
    seed = lfsr(seed);
    b = seed[7:0];
    wr(ADDR_PIN_TRIP, a);
    wr(ADDR_SYS_OPTS, b);
    chk_opts(a, b);
    wr(ADDR_PIN_TRIP, ~a);
    wr(ADDR_SYS_OPTS, ~b);
    rd(ADDR_PIN_TRIP, a & 8'h98);
    rd(ADDR_SYS_OPTS, b & SYS_WMASK);
    $display("test write once done");
    rst(1'b0);
    rd(ADDR_PIN_TRIP, a & 8'h18);
    rd(ADDR_SYS_OPTS, 8'h00);
    // the bench clock stands for an internal oscillator, not a crystal
    wr(ADDR_SYS_OPTS, 8'h0a);
    stop_run(n);
    chk("short", 32'(RS) + WAKE_LAT, n);
    rst(1'b0);
    wr(ADDR_SYS_OPTS, 8'h02);
    stop_run(n);
    chk("long", 32'(RL) + WAKE_LAT, n);
    $display("test recovery done");
    rst(1'b0);
    wr(ADDR_SYS_OPTS, 8'h0a);
    pulse_stop();
    rst(1'b0);
    wait_res(n);
    chk("reset exit", 32'(RL) + RST_LAT, n);
    rst(1'b1);
    chk_opts(8'h00, 8'h00);
    rd(ADDR_PIN_TRIP, 8'h00);
    repeat (2) @(negedge mclk);
    $display("test reset exit done");
    wrap_up();
  end
endmodule
